// ===== core/sclk_pkg.sv
// Constants, codes and carrier types of the switching clock selector
package sclk_pkg;

    // ==========================================================
    // Clock rates and timing counts
    // ==========================================================
    localparam int PCLK_KHZ = 20000; // Bus clock rate
    localparam int REF_KHZ = 8000; // Divider reference rate
    localparam int EXT_MIN_KHZ = 200; // Slowest accepted shared clock
    localparam int EXT_MAX_KHZ = 2000; // Fastest accepted shared clock
    // Longest accepted period rounds down, shortest rounds up
    localparam int EXT_MAX_PER = PCLK_KHZ / EXT_MIN_KHZ;
    localparam int EXT_MIN_PER = (PCLK_KHZ + EXT_MAX_KHZ - 1) / EXT_MAX_KHZ;
    localparam int DET_PERIODS = 3; // Search window in slowest periods
    localparam int DET_CYC = DET_PERIODS * EXT_MAX_PER;
    localparam int GOOD_NEED = 2; // Good periods that prove a clock
    localparam int BOOT_CYC = 4; // Cycles before straps are captured

    // ==========================================================
    // Divisors of the reference
    // ==========================================================
    localparam logic [5:0] DIV_MIN = 6'h04;
    localparam logic [5:0] DIV_MAX = 6'h28;
    localparam logic [5:0] DIV_LOW = 6'h28; // 200 kHz
    localparam logic [5:0] DIV_OPEN = 6'h14; // 400 kHz
    localparam logic [5:0] DIV_HIGH = 6'h08; // 1 MHz
    localparam logic [5:0] DIV_SYNC_OUT = 6'h14; // 400 kHz driven out
    localparam logic [5:0] DIV_RST = 6'h14; // Serial divisor at reset
    localparam int RES_CODES = 21; // Tabulated resistor settings

    // ==========================================================
    // Strap level codes
    // ==========================================================
    localparam logic [1:0] LVL_LOW = 2'h0;
    localparam logic [1:0] LVL_OPEN = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_RES = 2'h3; // Resistor to signal_ground

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIV = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_ACT_DIV = 8'h0C;
    localparam int CTRL_SERIAL_BIT = 0; // Use serial divisor
    localparam logic CTRL_RST = 1'b0;

    // Controller states
    typedef enum logic [2:0] {
        ST_BOOT, ST_IDLE, ST_DETECT, ST_LOCKED, ST_INTERNAL, ST_NOCLK
    } sclk_state_t;

    // Straps caught once at start-up
    typedef struct packed {
        logic [1:0] cfg; // Mode strap level
        logic [1:0] sync; // Shared pin strap level
        logic [5:0] res_div; // Divisor decoded from resistor
    } sclk_strap_t;

    // Status word layout, low bits of the status register
    typedef struct packed {
        logic lost; // Locked clock vanished
        logic det_fail; // Last search found no clock
        logic locked; // Following the shared clock
        logic [1:0] cfg; // Captured mode strap
        logic [2:0] state; // Controller state
    } sclk_status_t;

endpackage : sclk_pkg

// ===== core/sclk_div_rom.sv
// Resistor code to reference divisor lookup with registered output
`timescale 1ns/100ps
module sclk_div_rom
    import sclk_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [4:0] addr,
    output logic [5:0] rd_div
);

    // ==========================================================
    // Lookup, nearest whole divisor of the reference per setting
    // ==========================================================
    logic [5:0] next_rd_div; // Combinational table value

    always_comb begin
        case (addr)
            5'h00: next_rd_div = 6'h28; // 200 kHz
            5'h01: next_rd_div = 6'h24;
            5'h02: next_rd_div = 6'h21;
            5'h03: next_rd_div = 6'h1E;
            5'h04: next_rd_div = 6'h1B;
            5'h05: next_rd_div = 6'h19;
            5'h06: next_rd_div = 6'h16;
            5'h07: next_rd_div = 6'h14; // 400 kHz
            5'h08: next_rd_div = 6'h13;
            5'h09: next_rd_div = 6'h11;
            5'h0A: next_rd_div = 6'h0F;
            5'h0B: next_rd_div = 6'h0E;
            5'h0C: next_rd_div = 6'h0D;
            5'h0D: next_rd_div = 6'h0C;
            5'h0E: next_rd_div = 6'h0B;
            5'h0F: next_rd_div = 6'h09;
            5'h10: next_rd_div = 6'h08; // 1 MHz
            5'h11: next_rd_div = 6'h07;
            5'h12: next_rd_div = 6'h06;
            5'h13: next_rd_div = 6'h05;
            5'h14: next_rd_div = 6'h04; // 2 MHz
            // Out of table codes fall back to the open-pin rate
            default: next_rd_div = DIV_OPEN;
        endcase
    end

    // Registered read port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_div <= DIV_OPEN;
        end else begin
            rd_div <= next_rd_div;
        end
    end

endmodule : sclk_div_rom

// ===== core/sclk_select.sv
// Switching clock source selection, detection and generation
// Functional notes
// - Open mode strap: search shared pin after enable
// - Valid clock found: follow its rising edges
// - No clock: pin low/open/high gives 200/400/1000k
// - Pin strap caught once at start-up only
// - Resistor selects one of 21 tabulated rates
// - Serial rate is 8 MHz over N, 4..40
// - Readback reports quantised divisor actually used
// - High mode strap: drive 400 kHz, never search; with the serial bit set the code drives 8 MHz over N instead
// - Low mode strap: search on every enable
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/100ps
module sclk_select
    import sclk_pkg::*;
#(
    parameter int SYNC_STAGES = 2 // Synchroniser depth for pins
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic en_pin,
    input wire logic [1:0] cfg_strap,
    input wire logic [1:0] sync_strap,
    input wire logic [4:0] sync_res_code,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe,
    output logic sw_clk
);

    initial begin
        if (SYNC_STAGES != 2) $error("SYNC_STAGES must be 2");
    end

    // ==========================================================
    // Pin synchronisers, one two-flop chain per bit
    // ==========================================================
    localparam int PW = 11; // Pin bits brought across
    logic [PW-1:0] pin_raw; // Asynchronous pin levels
    logic [PW-1:0] pin_s1; // First stage, read only by second
    logic [PW-1:0] pin_s2; // Safe synchronised levels
    assign pin_raw = {en_pin, cfg_strap, sync_strap, sync_res_code,
                      sync_in};

    genvar gi;
    generate
        for (gi = 0; gi < PW; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                end else begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                end
            end
        end
    endgenerate

    logic en_s; // Enable, synchronised
    logic sync_s; // Shared clock level, synchronised
    logic sync_d; // Previous shared clock level
    logic en_d; // Previous enable
    assign en_s = pin_s2[10];
    assign sync_s = pin_s2[0];

    // Edge history of the synchronised pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_d <= 1'b0;
            en_d <= 1'b0;
        end else begin
            sync_d <= sync_s;
            en_d <= en_s;
        end
    end

    logic sync_rise; // Rising edge on the shared line
    logic en_rise; // Enable just asserted
    assign sync_rise = sync_s & ~sync_d;
    assign en_rise = en_s & ~en_d;

    // ==========================================================
    // Resistor decode table and start-up strap capture
    // ==========================================================
    logic [5:0] rom_div; // Divisor for the sensed resistor
    sclk_div_rom u_rom (
        .pclk(pclk),
        .presetn(presetn),
        .addr(pin_s2[5:1]),
        .rd_div(rom_div)
    );

    sclk_strap_t strap; // Straps held until the next reset
    logic [2:0] boot_cnt; // Start-up settle counter
    logic boot_done; // Straps captured

    // Straps are caught once after reset; later pin changes are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt <= 3'h0;
            boot_done <= 1'b0;
            strap <= '0;
        end else if (!boot_done) begin
            boot_cnt <= boot_cnt + 3'h1;
            if (boot_cnt == 3'(BOOT_CYC)) begin
                boot_done <= 1'b1;
                strap.cfg <= pin_s2[9:8];
                strap.sync <= pin_s2[7:6];
                strap.res_div <= rom_div;
            end
        end
    end

    // ==========================================================
    // Register file
    // ==========================================================
    logic ctrl_serial; // Use the serial divisor
    logic [5:0] div_reg; // Serial divisor N
    logic [5:0] act_div; // Divisor actually in use
    sclk_state_t state; // Controller state
    logic det_fail; // Last search failed
    logic lost; // Locked clock disappeared
    sclk_status_t status; // Packed status word

    logic setup_ph; // Setup phase seen, answer next cycle
    logic wr_ok; // Write completing this cycle, any address
    logic div_bad; // Serial divisor outside 4..40
    assign setup_ph = psel & ~penable & ~pready;
    assign div_bad = (pwdata[5:0] < DIV_MIN) || (pwdata[5:0] > DIV_MAX)
                     || (pwdata[31:6] != '0);
    assign wr_ok = pready & psel & penable & pwrite;

    always_comb begin
        status = '0;
        status.lost = lost;
        status.det_fail = det_fail;
        status.locked = (state == ST_LOCKED);
        status.cfg = strap.cfg;
        status.state = state;
    end

    // APB answer: every access completes with no wait state, pready from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup_ph;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (setup_ph) begin
                case (paddr)
                    REG_CTRL: prdata <= {31'h0, ctrl_serial};
                    REG_DIV: begin
                        prdata <= {26'h0, div_reg};
                        pslverr <= pwrite & div_bad;
                    end
                    REG_STATUS: prdata <= {24'h0, status};
                    REG_ACT_DIV: prdata <= {26'h0, act_div};
                    // Unmapped: error, reads zero
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // Writes land at the completing edge; out of range N is refused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_serial <= CTRL_RST;
            div_reg <= DIV_RST;
        end else if (wr_ok) begin
            if (paddr == REG_CTRL) begin
                ctrl_serial <= pwdata[CTRL_SERIAL_BIT];
            end
            if (paddr == REG_DIV && !div_bad) begin
                div_reg <= pwdata[5:0];
            end
        end
    end

    // ==========================================================
    // Divisor selection, one reference divider serves every rate
    // ==========================================================
    logic [5:0] next_act_div; // Divisor for the internal oscillator

    always_comb begin
        if (ctrl_serial) begin
            next_act_div = div_reg;
        end else if (strap.cfg == LVL_HIGH) begin
            next_act_div = DIV_SYNC_OUT;
        end else begin
            case (strap.sync)
                LVL_LOW: next_act_div = DIV_LOW;
                LVL_OPEN: next_act_div = DIV_OPEN;
                LVL_HIGH: next_act_div = DIV_HIGH;
                LVL_RES: next_act_div = strap.res_div;
                default: next_act_div = DIV_OPEN;
            endcase
        end
    end

    // ==========================================================
    // Controller: search, lock, fall back
    // ==========================================================
    logic [8:0] win_cnt; // Search window counter
    logic [7:0] per_cnt; // Cycles since the last rising edge
    logic [1:0] good_cnt; // Consecutive good periods
    logic per_ok; // Last period inside the legal range
    assign per_ok = (per_cnt >= 8'(EXT_MIN_PER - 1)) &&
                    (per_cnt <= 8'(EXT_MAX_PER - 1));

    // Period meter, saturating so a dead line is seen as too slow
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt <= 8'hFF;
        end else if (sync_rise) begin
            per_cnt <= 8'h0;
        end else if (per_cnt != 8'hFF) begin
            per_cnt <= per_cnt + 8'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_BOOT;
            win_cnt <= 9'h0;
            good_cnt <= 2'h0;
            det_fail <= 1'b0;
            lost <= 1'b0;
        end else begin
            case (state)
                ST_BOOT: begin
                    if (boot_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    win_cnt <= 9'h0;
                    good_cnt <= 2'h0;
                    if (en_rise && strap.cfg == LVL_HIGH) begin
                        state <= ST_INTERNAL;
                    end else if (en_rise) begin
                        state <= ST_DETECT;
                        det_fail <= 1'b0;
                        lost <= 1'b0;
                    end
                end
                ST_DETECT: begin
                    win_cnt <= win_cnt + 9'h1;
                    if (sync_rise) begin
                        good_cnt <= per_ok ? good_cnt + 2'h1 : 2'h0;
                    end
                    if (!en_s) begin
                        state <= ST_IDLE;
                    end else if (good_cnt == 2'(GOOD_NEED)) begin
                        state <= ST_LOCKED;
                    end else if (win_cnt == 9'(DET_CYC)) begin
                        det_fail <= 1'b1;
                        // Input mode has no own rate to fall back on
                        state <= (strap.cfg == LVL_OPEN) ?
                                 ST_INTERNAL : ST_NOCLK;
                    end
                end
                ST_LOCKED: begin
                    if (!en_s) begin
                        state <= ST_IDLE;
                    end else if (per_cnt == 8'(EXT_MAX_PER)) begin
                        lost <= 1'b1;
                        state <= (strap.cfg == LVL_OPEN) ?
                                 ST_INTERNAL : ST_NOCLK;
                    end
                end
                ST_INTERNAL, ST_NOCLK: begin
                    if (!en_s) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Internal oscillator from an 8 MHz fractional reference
    // ==========================================================
    logic [15:0] ref_acc; // Fractional phase of the reference
    logic ref_tick; // One reference period elapsed
    logic [5:0] ph_cnt; // Reference ticks into this period
    logic osc_run; // Internal oscillator in use
    assign ref_tick = (ref_acc + 16'(REF_KHZ)) >= 16'(PCLK_KHZ);
    assign osc_run = (state == ST_INTERNAL);

    // Ticks average 8 MHz; jitter is one bus clock, traded for no PLL
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_acc <= 16'h0;
        end else if (ref_tick) begin
            ref_acc <= ref_acc + 16'(REF_KHZ) - 16'(PCLK_KHZ);
        end else begin
            ref_acc <= ref_acc + 16'(REF_KHZ);
        end
    end

    // Period counter; divisor changes take effect at a period boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ph_cnt <= 6'h0;
            act_div <= DIV_OPEN;
        end else if (!osc_run) begin
            ph_cnt <= 6'h0;
            act_div <= next_act_div;
        end else if (ref_tick) begin
            if (ph_cnt >= act_div - 6'h1) begin
                ph_cnt <= 6'h0;
                act_div <= next_act_div;
            end else begin
                ph_cnt <= ph_cnt + 6'h1;
            end
        end
    end

    // ==========================================================
    // Clock outputs
    // ==========================================================
    logic osc_lvl; // Internal oscillator level
    assign osc_lvl = osc_run && (ph_cnt < {1'b0, act_div[5:1]});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_clk <= 1'b0;
            sync_out <= 1'b0;
            sync_oe <= 1'b0;
        end else begin
            // Locked: follow the line, so phase matches its rising edge
            sw_clk <= (state == ST_LOCKED) ? sync_s : osc_lvl;
            // Only the output-strapped part ever drives the line
            sync_oe <= boot_done && (strap.cfg == LVL_HIGH);
            sync_out <= (strap.cfg == LVL_HIGH) && osc_lvl;
        end
    end

endmodule : sclk_select

// ===== dv/sclk_select_props.sv
// Port checker for the switching clock selector
`timescale 1ns/100ps
module sclk_select_props
    import sclk_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] cfg_strap,
    input wire logic sync_in,
    input wire logic sync_out,
    input wire logic sync_oe,
    input wire logic sw_clk
);
    // Half period of the fixed driven clock, in pclk cycles
    localparam int OUT_HALF = PCLK_KHZ * DIV_SYNC_OUT / REF_KHZ / 2;
    int out_hi; // Current high run of sync_out
    int sw_hi; // Current high run of sw_clk
    logic armed; // A run has ended

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Run counters
    // ==========================================================
    // Cleared on every low cycle, so each counts one high run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) out_hi <= 0;
        else out_hi <= sync_out ? out_hi + 1 : 0;
    end
    // Same for the switching clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sw_hi <= 0;
        else sw_hi <= sw_clk ? sw_hi + 1 : 0;
    end
    // First run starts between ticks, so skip it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) armed <= 1'b0;
        else if (sw_hi > 0 && !sw_clk) armed <= 1'b1;
    end

    // ==========================================================
    // Sequences and checks
    // ==========================================================
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_out_end;
        $fell(sync_out) && cfg_strap == LVL_HIGH && armed;
    endsequence
    sequence s_sw_end;
        $fell(sw_clk) && cfg_strap == LVL_HIGH && armed;
    endsequence

    a_ready_setup: assert property (s_setup |=> pready)
        else $error("no answer one cycle after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_err_rd_zero: assert property (pslverr && !pwrite |-> !prdata)
        else $error("refused read returned data");
    a_drive_mode: assert property (sync_oe |-> cfg_strap == LVL_HIGH)
        else $error("shared pin driven outside output mode");
    a_drive_qual: assert property (sync_out |-> sync_oe)
        else $error("drive value without drive enable");
    a_out_half: assert property (s_out_end |-> out_hi == OUT_HALF)
        else $error("driven clock half period wrong");
    a_sw_half: assert property (s_sw_end |-> sw_hi == OUT_HALF)
        else $error("internal clock half period wrong");
    a_input_follow: assert property (
        cfg_strap == LVL_LOW && sw_clk |-> $past(sync_in, 3))
        else $error("switching clock not following shared clock");
endmodule : sclk_select_props

bind sclk_select sclk_select_props i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg_strap(cfg_strap), .sync_in(sync_in),
    .sync_out(sync_out), .sync_oe(sync_oe), .sw_clk(sw_clk));

// ===== dv/sclk_sync_src.sv
// Model of another converter driving the shared clock line
`timescale 1ns/100ps
module sclk_sync_src #(
    parameter int HALF_NS = 1000 // Half period, inside 200 kHz..2 MHz
)(
    input wire logic run,
    output logic clk_o
);
    // Free phase against pclk; line stands low while not running
    initial begin
        clk_o = 1'b0;
        #137;
        forever begin
            #(HALF_NS);
            clk_o = run ? ~clk_o : 1'b0;
        end
    end
endmodule : sclk_sync_src

// ===== dv/tb.sv
// Self-checking bench for the switching clock selector
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb
    import sclk_pkg::*;
;
    localparam int SRC_HALF = 1000; // Partner half period in ns
    // Resistor table rates in kHz, in code order
    localparam int RES_KHZ [21] = '{200, 222, 242, 267, 296, 320, 364,
        400, 421, 471, 533, 571, 615, 667, 727, 889, 1000, 1143, 1333,
        1600, 2000};
    logic pclk, presetn, psel, penable, pwrite, en_pin, src_run, src_clk;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, sync_in, sync_out, sync_oe, sw_clk;
    logic [1:0] cfg_strap, sync_strap;
    logic [4:0] sync_res_code;
    int err_count = 0;
    int checks = 0;
    logic [33:0] q[$]; // Notes: check data, data, error

    sclk_select i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .en_pin(en_pin), .cfg_strap(cfg_strap),
        .sync_strap(sync_strap), .sync_res_code(sync_res_code),
        .sync_in(sync_in), .sync_out(sync_out), .sync_oe(sync_oe),
        .sw_clk(sw_clk));
    sclk_sync_src #(.HALF_NS(SRC_HALF)) i_src (.run(src_run),
        .clk_o(src_clk));
    // Shared line level: our drive wins, else the partner's
    assign sync_in = sync_oe ? sync_out : src_clk;

    // ==========================================================
    // Clock, tasks and result watcher
    // ==========================================================
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic finish_test();
        if (err_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    // Reset with new straps, held through capture
    task automatic rst(input logic [1:0] cf, st, input logic [4:0] rc);
        @(posedge pclk);
        presetn <= 1'b0;
        en_pin <= 1'b0;
        cfg_strap <= cf;
        sync_strap <= st;
        sync_res_code <= rc;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
    endtask : rst

    // Enable change, then room for search and settling
    task automatic en(input logic v);
        @(posedge pclk);
        en_pin <= v;
        repeat (350) @(posedge pclk);
    endtask : en

    // One APB transfer; the expected answer goes on the queue
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic er, input logic [31:0] rd);
        int t = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        q.push_back({~wr, rd, er});
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++t < 50);
        if (t == 50) err_count++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Cycles spanned by two whole periods of sw_clk
    task automatic meas(output int n);
        int r;
        logic p;
        n = 0;
        r = 0;
        p = sw_clk;
        while (r < 3 && n < 2000) begin
            @(negedge pclk);
            if (sw_clk === 1'b1 && p === 1'b0) r++;
            if (r > 0) n++;
            p = sw_clk;
        end
        n = n - 1;
    endtask : meas

    // Oldest note is matched against each answer
    always @(negedge pclk) begin
        logic [33:0] e;
        if (pready === 1'b1) begin
            e = q.size() ? q.pop_front() : 34'h0;
            `CHK("pslverr", e[0], pslverr)
            if (e[33]) `CHK("prdata", e[32:1], prdata)
        end
    end

    // Hang guard, well above the expected run length
    initial begin
        #(40000 * 50);
        err_count++;
        finish_test();
    end

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        logic [31:0] n;
        int c, m;
        void'($urandom(7));
        {presetn, psel, penable, pwrite, en_pin, src_run} = 6'h00;
        {paddr, pwdata, cfg_strap, sync_strap, sync_res_code} = 0;
        // Input mode: lock, then a fresh search finds nothing
        src_run <= 1'b1;
        rst(LVL_LOW, LVL_OPEN, 5'h00);
        en(1'b1);
        apb(1'b0, REG_STATUS, 0, 1'b0, 32'h23);
        meas(m);
        `CHK("lock period", 4 * SRC_HALF / 50, m)
        en(1'b0);
        src_run <= 1'b0;
        en(1'b1);
        apb(1'b0, REG_STATUS, 0, 1'b0, 32'h45);
        `CHK("no clock", 1'b0, sw_clk)
        // Auto mode: clock present, then each strap level, resistor
        for (int i = 0; i < 5; i++) begin
            c = $urandom_range(20, 0);
            n = (i == 1) ? DIV_LOW : (i == 2) ? DIV_OPEN :
                (i == 3) ? DIV_HIGH : (8000 + RES_KHZ[c] / 2) / RES_KHZ[c];
            src_run <= (i == 0);
            rst(LVL_OPEN, 2'(i - 1), 5'(c));
            en(1'b1);
            if (i == 0) apb(1'b0, REG_STATUS, 0, 1'b0, 32'h2B);
            else begin
                apb(1'b0, REG_ACT_DIV, 0, 1'b0, n);
                meas(m);
                `CHK("strap period", 2 * n * PCLK_KHZ / REF_KHZ, m)
            end
        end
        apb(1'b0, REG_STATUS, 0, 1'b0, 32'h4C);
        // Strap change after capture is ignored
        sync_strap <= LVL_HIGH;
        en(1'b0);
        en(1'b1);
        apb(1'b0, REG_ACT_DIV, 0, 1'b0, n);
        // Serial divisor: both bounds and a random one
        apb(1'b1, REG_CTRL, 32'h1, 1'b0, 0);
        for (int i = 0; i < 3; i++) begin
            n = (i == 0) ? DIV_MIN : (i == 1) ? DIV_MAX : $urandom_range(39, 5);
            apb(1'b1, REG_DIV, n, 1'b0, 0);
            repeat (300) @(posedge pclk);
            apb(1'b0, REG_ACT_DIV, 0, 1'b0, n);
            meas(m);
            `CHK("serial period", 2 * n * PCLK_KHZ / REF_KHZ, m)
        end
        // Out-of-range and unmapped accesses are refused
        apb(1'b1, REG_DIV, 32'h3, 1'b1, 0);
        apb(1'b1, REG_DIV, 32'h29, 1'b1, 0);
        apb(1'b1, REG_DIV, 32'h114, 1'b1, 0);
        apb(1'b0, REG_ACT_DIV, 0, 1'b0, n);
        apb(1'b0, 8'h10, 0, 1'b1, 0);
        // Output mode drives the fixed clock and never searches
        rst(LVL_HIGH, LVL_OPEN, 5'h00);
        `CHK("drive enable", 1'b1, sync_oe)
        en(1'b1);
        apb(1'b1, REG_STATUS, 32'hFF, 1'b0, 0);
        apb(1'b0, REG_STATUS, 0, 1'b0, 32'h14);
        meas(m);
        `CHK("out period", 2 * DIV_SYNC_OUT * PCLK_KHZ / REF_KHZ, m)
        finish_test();
    end
endmodule : tb
